// ==== smdl_defs.svh ====
// Register offsets, field positions, reset values and timing constants of the serial master
// Summary of operation
// - Transfer-done flag sets at end of each byte; cleared by status read then data access.
// - Write-collision flag sets on data write during a transfer; cleared like transfer-done.
// - Mode-fault sets when master sees select input low; cleared by status read then control write.
// - With enable and master select set, a data write starts a one-byte full-duplex exchange.
// - Control holds irq enable, enable, open drain, master, polarity, phase, two rate bits.
// - Status: transfer-done bit 7, collision bit 6, mode-fault bit 4, others zero; reset zero.
// - A three-wire bus is equivalent when polarity and phase are both zero.
// - Unipolar code is straight binary: output is reference times code over 4096.
// - Bipolar code is offset binary: reference times twice code over 4096 minus one.
// - Rate bits divide the processor clock by 2, 4, 16 or 32.
// - Serial clock idles high when polarity is set, low when clear.
// - With irq enable set, request raised while transfer-done or mode-fault is set.
`ifndef SMDL_DEFS_SVH
`define SMDL_DEFS_SVH
`define SMDL_OFS_PORT_DATA   6'h08
`define SMDL_OFS_PORT_DIR    6'h09
`define SMDL_OFS_CONTROL     6'h28
`define SMDL_OFS_STATUS      6'h29
`define SMDL_OFS_DATA        6'h2a
`define SMDL_CTL_RESET       8'h04
`define SMDL_BIT_IRQ_EN      7
`define SMDL_BIT_ENABLE      6
`define SMDL_BIT_OPEN_DRAIN  5
`define SMDL_BIT_MASTER      4
`define SMDL_BIT_CLOCK_IDLE_POLARITY        3
`define SMDL_BIT_CLOCK_PHASE_SELECT        2
`define SMDL_BIT_DONE        7
`define SMDL_BIT_WRITE_COLLISION_FLAG        6
`define SMDL_BIT_MODE_FAULT_FLAG        4
`define SMDL_PIN_SS          5
`define SMDL_PIN_SCK         4
`define SMDL_PIN_MOSI        3
`define SMDL_PIN_MISO        2
`define SMDL_PORT_MASK       8'h3f
`define SMDL_HALF_DIV2       5'h00
`define SMDL_HALF_DIV4       5'h01
`define SMDL_HALF_DIV16      5'h07
`define SMDL_HALF_DIV32      5'h0f
`define SMDL_BITS_PER_BYTE   4'h7
`define SMDL_FIFO_DEPTH      16
`endif

// ==== smdl_pkg.sv ====
// Types shared by the serial master
package smdl_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} smdl_state_e;
endpackage

// ==== smdl_fifo.sv ====
// Valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
`default_nettype none
module smdl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    output var  logic [WIDTH-1:0] out_data,
    output var  logic             out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } smdl_fifo_s;
    smdl_fifo_s             st_r;
    smdl_fifo_s             st_nxt;
    logic [WIDTH-1:0]       mem [DEPTH];
    logic                   push;
    logic                   pop;

    assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (st_r.cnt != '0);
    assign out_data  = mem[st_r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wp = st_r.wp + 1'b1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[st_r.wp] <= in_data;
        end
    end
endmodule
`default_nettype wire

// ==== smdl_master.sv ====
// Serial master peripheral with port, control, status and data registers
`timescale 1ns/1ps
`default_nettype none
`include "smdl_defs.svh"
module smdl_master (
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic [5:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic [5:0] port_in,
    output logic      [5:0] port_out,
    output logic      [5:0] port_oe,
    output logic            irq_n,
    output logic      [7:0] rx_data,
    output logic            rx_valid,
    input  wire logic       rx_ready
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        smdl_pkg::smdl_state_e state;
        logic [7:0]            ctl;
        logic [7:0]            pdata;
        logic [7:0]            pdir;
        logic [7:0]            shift;
        logic [7:0]            rdbuf;
        logic                  done;
        logic                  write_collision_flag;
        logic                  mode_fault_flag;
        logic                  stat_seen;
        logic [4:0]            div;
        logic [2:0]            bitn;
        logic                  sck;
        logic                  sampled;
        logic [7:0]            rdata;
        logic [5:0]            pout;
        logic [5:0]            poe;
        logic                  irq_n;
        logic                  push;
    } smdl_master_s;
    smdl_master_s st_r;
    smdl_master_s st_nxt;
    logic         fifo_ready;
    logic [4:0]   half;
    logic         active;
    logic         master_on;
    logic         data_acc;
    logic         stat_rd;

    // ----------------------------------------------------------------
    // Receive queue
    // ----------------------------------------------------------------
    // Received bytes queue for a streaming consumer; a full queue drops nothing from registers
    smdl_fifo #(.WIDTH(8), .DEPTH(`SMDL_FIFO_DEPTH)) u_fifo (
        .clock     (clock),
        .rstn      (rstn),
        .in_data   (st_r.rdbuf),
        .in_valid  (st_r.push),
        .in_ready  (fifo_ready),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    assign reg_rdata = st_r.rdata;
    assign port_out  = st_r.pout;
    assign port_oe   = st_r.poe;
    assign irq_n     = st_r.irq_n;
    assign active    = (st_r.state != smdl_pkg::ST_IDLE);
    assign master_on = st_r.ctl[`SMDL_BIT_ENABLE] && st_r.ctl[`SMDL_BIT_MASTER];
    assign data_acc  = (reg_wr || reg_rd) && reg_addr == `SMDL_OFS_DATA;
    assign stat_rd   = reg_rd && reg_addr == `SMDL_OFS_STATUS;

    always_comb begin
        unique case (st_r.ctl[1:0])
            2'b00:   half = `SMDL_HALF_DIV2;
            2'b01:   half = `SMDL_HALF_DIV4;
            2'b10:   half = `SMDL_HALF_DIV16;
            default: half = `SMDL_HALF_DIV32;
        endcase
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [5:0] drv;
        logic       clock_idle_polarity;
        logic       clock_phase_select;
        logic       end_byte;
        logic       in_bit;
        drv      = '0;
        clock_idle_polarity     = st_r.ctl[`SMDL_BIT_CLOCK_IDLE_POLARITY];
        clock_phase_select     = st_r.ctl[`SMDL_BIT_CLOCK_PHASE_SELECT];
        end_byte = 1'b0;
        in_bit   = (clock_phase_select || st_r.div == half) ? port_in[`SMDL_PIN_MISO] : st_r.sampled;
        st_nxt   = st_r;
        st_nxt.push = st_r.push && !fifo_ready;

        // Status read arms the clear; the later data access or control write completes it
        if (stat_rd) begin
            st_nxt.stat_seen = 1'b1;
        end
        if (data_acc && st_r.stat_seen) begin
            st_nxt.done      = 1'b0;
            st_nxt.write_collision_flag      = 1'b0;
            st_nxt.stat_seen = 1'b0;
        end
        if (reg_wr && reg_addr == `SMDL_OFS_CONTROL) begin
            st_nxt.ctl = reg_wdata;
            if (st_r.stat_seen) begin
                st_nxt.mode_fault_flag      = 1'b0;
                st_nxt.stat_seen = 1'b0;
            end
        end
        if (reg_wr && reg_addr == `SMDL_OFS_PORT_DATA) begin
            st_nxt.pdata = reg_wdata & `SMDL_PORT_MASK;
        end
        if (reg_wr && reg_addr == `SMDL_OFS_PORT_DIR) begin
            st_nxt.pdir = reg_wdata & `SMDL_PORT_MASK;
        end

        // ----------------------------------------------------------------
        // Serial engine
        // ----------------------------------------------------------------
        unique case (st_r.state)
            smdl_pkg::ST_IDLE: begin
                st_nxt.sck = clock_idle_polarity;
                if (reg_wr && reg_addr == `SMDL_OFS_DATA && master_on) begin
                    // Converter codes pass bit-exact; their meaning lies at the far side
                    st_nxt.shift = reg_wdata;
                    st_nxt.div   = half;
                    st_nxt.bitn  = '0;
                    st_nxt.state = smdl_pkg::ST_LEAD;
                end
            end
            smdl_pkg::ST_LEAD: begin
                if (st_r.div == '0) begin
                    st_nxt.div   = half;
                    st_nxt.sck   = !st_r.sck;
                    st_nxt.state = smdl_pkg::ST_TRAIL;
                end else begin
                    st_nxt.div = st_r.div - 5'h01;
                end
            end
            smdl_pkg::ST_TRAIL: begin
                // Pin lags the register by a cycle: read the input in the first trailing cycle, before the pin shows the edge
                if (!clock_phase_select && st_r.div == half) begin
                    st_nxt.sampled = port_in[`SMDL_PIN_MISO];
                end
                if (st_r.div == '0) begin
                    st_nxt.div = half;
                    st_nxt.sck = !st_r.sck;
                    st_nxt.shift = {st_r.shift[6:0], in_bit};
                    if (st_r.bitn == `SMDL_BITS_PER_BYTE) begin
                        st_nxt.state = smdl_pkg::ST_IDLE;
                        end_byte     = 1'b1;
                    end else begin
                        st_nxt.bitn  = st_r.bitn + 3'h1;
                        st_nxt.state = smdl_pkg::ST_LEAD;
                    end
                end else begin
                    st_nxt.div = st_r.div - 5'h01;
                end
            end
            default: st_nxt.state = smdl_pkg::ST_IDLE;
        endcase
        if (end_byte) begin
            st_nxt.done  = 1'b1;
            st_nxt.rdbuf = st_nxt.shift;
            st_nxt.push  = 1'b1;
        end
        // Collision: data register not reloaded, byte in flight continues
        if (reg_wr && reg_addr == `SMDL_OFS_DATA && active) begin
            st_nxt.write_collision_flag = 1'b1;
        end
        if (master_on && !port_in[`SMDL_PIN_SS] && !st_r.pdir[`SMDL_PIN_SS]) begin
            st_nxt.mode_fault_flag  = 1'b1;
        end
        if (st_nxt.mode_fault_flag) begin
            st_nxt.ctl[`SMDL_BIT_MASTER] = 1'b0;
            st_nxt.state                 = smdl_pkg::ST_IDLE;
        end

        // Pin drive: serial pins when enabled as master, port otherwise
        st_nxt.pout = st_r.pdata[5:0];
        drv         = st_r.pdir[5:0];
        if (master_on) begin
            st_nxt.pout[`SMDL_PIN_SCK]  = st_r.sck;
            st_nxt.pout[`SMDL_PIN_MOSI] = st_r.shift[7];
            drv[`SMDL_PIN_MISO]         = 1'b0;
        end
        // Open drain drives only low levels
        st_nxt.poe = st_r.ctl[`SMDL_BIT_OPEN_DRAIN] ? (drv & ~st_nxt.pout) : drv;

        st_nxt.irq_n = !(st_r.ctl[`SMDL_BIT_IRQ_EN] && (st_r.done || st_r.mode_fault_flag));

        // ----------------------------------------------------------------
        // Read data
        // ----------------------------------------------------------------
        unique case (reg_addr)
            `SMDL_OFS_PORT_DATA: st_nxt.rdata = {2'b00, port_in};
            `SMDL_OFS_PORT_DIR:  st_nxt.rdata = st_r.pdir;
            `SMDL_OFS_CONTROL:   st_nxt.rdata = st_r.ctl;
            `SMDL_OFS_STATUS:    st_nxt.rdata = {st_r.done, st_r.write_collision_flag, 1'b0, st_r.mode_fault_flag, 4'h0};
            `SMDL_OFS_DATA:      st_nxt.rdata = st_r.rdbuf;
            default:             st_nxt.rdata = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            st_r       <= '0;
            st_r.ctl   <= `SMDL_CTL_RESET;
            st_r.irq_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

// ==== smdl_master_chk.sv ====
// Port-level checker for the serial master
`timescale 1ns/1ps
`default_nettype none
`include "smdl_defs.svh"
module smdl_master_chk (
    input wire logic       clock,
    input wire logic       rstn,
    input wire logic [5:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [5:0] port_in,
    input wire logic [5:0] port_out,
    input wire logic [5:0] port_oe,
    input wire logic       irq_n,
    input wire logic [7:0] rx_data,
    input wire logic       rx_valid,
    input wire logic       rx_ready
);
    // ------------------------------
    // Shadow of control writes
    // ------------------------------
    // Misses the master bit dropped by a mode fault
    logic [7:0] ctl_r;
    logic       st_r;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctl_r <= `SMDL_CTL_RESET;
            st_r  <= 1'b0;
        end else begin
            st_r <= reg_rd && reg_addr == `SMDL_OFS_STATUS;
            if (reg_wr && reg_addr == `SMDL_OFS_CONTROL) begin
                ctl_r <= reg_wdata;
            end
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    AST_RESET_OUT: assert property ($rose(rstn) |-> irq_n && !rx_valid && port_oe == 6'h00)
        else $error("outputs busy after reset");
    AST_ST_UNUSED: assert property (st_r |-> (reg_rdata & 8'h2f) == 8'h00)
        else $error("unused status bits set");
    AST_RX_HOLD: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("stalled rx byte changed");
    AST_MOSI_EDGE: assert property (ctl_r[6] && ctl_r[4] && ctl_r[3] == ctl_r[2] && !$past(reg_wr)
        && $rose(port_out[4]) |-> $stable(port_out[3])) else $error("data moved on sample edge");
    AST_IRQ_MASK: assert property (!ctl_r[7] && !$past(ctl_r[7]) |-> irq_n)
        else $error("irq while disabled");
    AST_IRQ_FLAG: assert property (st_r && ctl_r[7] && $past(ctl_r[7]) &&
        (reg_rdata[7] || reg_rdata[4]) |-> !irq_n) else $error("irq missing");
    AST_OPEN_DRAIN: assert property (ctl_r[5] && $past(ctl_r[5]) |-> (port_oe & port_out) == 6'h00)
        else $error("open drain drives high");
    AST_RX_IDLE: assert property (ctl_r[6] && $rose(rx_valid) |-> port_out[4] == ctl_r[3])
        else $error("clock not idle after byte");
    COV_FULL: cover property (rx_valid && !rx_ready);
    COV_IRQ: cover property (!irq_n);
    COV_MODE_FAULT_FLAG: cover property (st_r && reg_rdata[4]);
endmodule
bind smdl_master smdl_master_chk u_chk (
    .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port_in(port_in), .port_out(port_out),
    .port_oe(port_oe), .irq_n(irq_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready)
);
`default_nettype wire

// ==== smdl_dac_model.sv ====
// Serial converter slave with a 16-bit delayed data output
`timescale 1ns/1ps
`default_nettype none
module smdl_dac_model (
    input  wire logic        cs_n,
    input  wire logic        sck,
    input  wire logic        mosi,
    output var  logic        miso,
    output var  logic [15:0] word_r
);
    logic [15:0] sh_r = 16'h0000;
    logic        out_r = 1'b0;
    // Mode 0 only: capture on rise, drive on fall
    always @(posedge sck) if (!cs_n) sh_r <= {sh_r[14:0], mosi};
    always @(negedge sck or negedge cs_n) if (!cs_n) out_r <= sh_r[15];
    always @(posedge cs_n) word_r <= sh_r;
    // Released line shows the inverse of its last level
    assign miso = cs_n ? ~out_r : out_r;
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Register-level testbench for the serial master
`timescale 1ns/1ps
`default_nettype none
`include "smdl_defs.svh"
module testbench;
    localparam logic [5:0]  A_PD = `SMDL_OFS_PORT_DATA;
    localparam logic [5:0]  A_DR = `SMDL_OFS_PORT_DIR;
    localparam logic [5:0]  A_CT = `SMDL_OFS_CONTROL;
    localparam logic [5:0]  A_ST = `SMDL_OFS_STATUS;
    localparam logic [5:0]  A_SD = `SMDL_OFS_DATA;
    localparam logic [15:0] HI [4] = '{16'h0001, 16'h0002, 16'h0008, 16'h0010};
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic [5:0]  reg_addr = 6'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_wdata = 8'h00;
    logic [7:0]  reg_rdata;
    logic [5:0]  port_out;
    logic [5:0]  port_oe;
    logic [5:0]  pin;
    logic        irq_n;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        rx_ready = 1'b0;
    logic        ss_in = 1'b1;
    logic        miso;
    logic [15:0] dac_word;
    logic [7:0]  s;
    logic [7:0]  sent [16];
    int          fail_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          n;
    int          k;
    // Undriven pins rest high on pull-ups
    assign pin = (port_out & port_oe) | ~port_oe;
    smdl_master DUT (
        .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .port_out(port_out), .port_oe(port_oe),
        .port_in({port_oe[5] ? pin[5] : ss_in, pin[4:3], miso, pin[1:0]}),
        .irq_n(irq_n), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready)
    );
    smdl_dac_model u_dac (.cs_n(pin[5]), .sck(pin[4]), .mosi(pin[3]), .miso(miso), .word_r(dac_word));
    initial forever #50 clock = ~clock;
    task automatic final_report();
        if (fail_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic rchk(input logic [5:0] a, input logic [7:0] e, input string nm);
        logic [7:0] v;
        rd(a, v);
        chk(nm, e, v);
    endtask
    task automatic wait_done(input logic [7:0] e);
        logic [7:0] v;
        int         t;
        v = 8'h00;
        t = 0;
        while (v[7] !== 1'b1 && t < 200) begin
            rd(A_ST, v);
            t++;
        end
        chk("status", e, v);
    endtask
    task automatic sck_wait(input logic lv, output int h);
        h = 0;
        #1;
        while (pin[4] !== lv && h < 40) begin
            @(posedge clock);
            #1;
            h++;
        end
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        rchk(A_ST, 8'h00, "status");
        rchk(A_CT, 8'h04, "control");
        wr(A_DR, 8'h38);
        wr(A_PD, 8'h2f);
        wr(A_CT, 8'h51);
        rchk(A_CT, 8'h51, "control");
        chk("sck_idle", 16'h0000, 16'(pin[4]));
        sent[0] = 8'h74;
        sent[1] = 8'h00;
        wr(A_PD, 8'h0f);
        wr(A_SD, sent[0]);
        wr(A_SD, 8'h55);
        wait_done(8'hc0);
        wr(A_SD, sent[1]);
        wait_done(8'h80);
        rchk(A_SD, 8'h00, "rx_byte");
        rchk(A_ST, 8'h00, "status");
        wr(A_PD, 8'h2f);
        repeat (2) @(posedge clock);
        chk("dac_word", 16'h7400, dac_word);
        chk("dac_code", 16'h0400, dac_word & 16'h0fff);
        wr(A_PD, 8'h0f);
        for (int i = 2; i < 16; i++) begin
            sent[i] = 8'(i * 29);
            wr(A_SD, sent[i]);
            wait_done(8'h80);
        end
        wr(A_PD, 8'h2f);
        chk("rx_full", 16'h0001, 16'(rx_valid));
        @(posedge clock);
        rx_ready <= 1'b1;
        #1;
        k = 0;
        n = 0;
        while (k < 16 && n < 100) begin
            if (rx_valid === 1'b1) begin
                chk("rx_data", k < 2 ? 16'h0000 : 16'(sent[k - 2]), 16'(rx_data));
                k++;
            end
            @(posedge clock);
            #1;
            n++;
        end
        chk("rx_empty", 16'h0000, 16'(rx_valid));
        chk("rx_count", 16'h0010, 16'(k));
        rd(A_SD, s);
        for (int r = 0; r < 4; r++) begin
            wr(A_CT, 8'hd0 | 8'(r));
            wr(A_SD, 8'h5a);
            sck_wait(1'b1, n);
            sck_wait(1'b0, n);
            sck_wait(1'b1, n);
            sck_wait(1'b0, n);
            chk("sck_high", HI[r], 16'(n));
            wait_done(8'h80);
            chk("irq", 16'h0000, 16'(irq_n));
            wr(A_CT, 8'h50 | 8'(r));
            repeat (2) @(posedge clock);
            chk("irq_masked", 16'h0001, 16'(irq_n));
            rd(A_ST, s);
            rd(A_SD, s);
            rchk(A_ST, 8'h00, "status");
        end
        wr(A_CT, 8'h58);
        repeat (3) @(posedge clock);
        chk("sck_idle", 16'h0001, 16'(pin[4]));
        wr(A_CT, 8'h70);
        repeat (2) @(posedge clock);
        chk("od_oe", 16'h0000, 16'(port_oe[5]));
        wr(A_CT, 8'h50);
        wr(A_DR, 8'h18);
        @(posedge clock);
        ss_in <= 1'b0;
        repeat (3) @(posedge clock);
        rchk(A_ST, 8'h10, "status");
        rchk(A_CT, 8'h40, "control");
        wr(A_SD, 8'h11);
        repeat (40) @(posedge clock);
        rchk(A_ST, 8'h10, "status");
        @(posedge clock);
        ss_in <= 1'b1;
        wr(A_CT, 8'h50);
        rchk(A_ST, 8'h00, "status");
        final_report();
    end
endmodule
`default_nettype wire
